// [design/host_supervision_pins_defines.svh]
// Constants for the host supervision pin logic
`ifndef HOST_SUPERVISION_PINS_DEFINES_SVH
`define HOST_SUPERVISION_PINS_DEFINES_SVH

// Bus address
`define BUS_ADDR_UPPER 6'h14
// Register offsets (own map)
`define REG_CTRL 4'h0
`define REG_OVERRIDE 4'h1
`define REG_WDT 4'h2
`define REG_STATUS 4'h3
`define REG_IRQ_STATUS 4'h4
`define REG_IRQ_MASK 4'h5
`define REG_CHSEL 4'h6
// Control register fields
`define CTRL_FET_TEMP_SEL 5
`define CTRL_TEMP_GAIN 4
`define CTRL_CELL_FAIL_EN 7
`define CTRL_OPEN_WIRE_EN 0
// Override register fields
`define OVR_FET 6
`define OVR_BAL 5
`define OVR_LMON 4
`define OVR_CMON 3
`define OVR_SCAN 2
`define OVR_NVM 0
// Analog selector codes for thermistor inputs
`define CHSEL_PACK_THERM 4'h1
`define CHSEL_AUX_THERM 4'h2
// Timing at 50 MHz
`define CLK_HZ 50000000
`define ALERT_PULSE_NS 1000
// Scaled in two steps so the product stays inside 32 bits
`define ALERT_PULSE_CYC (`CLK_HZ / 1000000 * `ALERT_PULSE_NS / 1000)
`define ALERT_PERIOD_HZ 1
`define ALERT_PERIOD_CYC (`CLK_HZ / `ALERT_PERIOD_HZ)
// One watchdog step of the timeout setting, in milliseconds
`define WDT_STEP_MS 1000
`define WDT_STEP_CYC (`CLK_HZ / 1000 * `WDT_STEP_MS)
// Event bits in the interrupt status register
`define EVT_TIMEOUT 0
`define EVT_RESUME 1
`define EVT_PACK_FAIL 2

`endif

// [design/host_supervision_pins_pkg.sv]
// Types for the host supervision pin logic
package host_supervision_pins_pkg;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_RUN,
    WD_TIMED_OUT
  } wd_state_e;

  typedef struct packed {
    logic [31:0] count;
    logic alert_n;
  } pulse_s;

  typedef struct packed {
    wd_state_e wd;
    logic [31:0] wd_count;
    logic [7:0] ctrl;
    logic [7:0] ovr;
    logic [4:0] wdt_set;
    logic [3:0] chsel;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    logic alert_n;
    logic irq;
    logic pack_fail;
    logic bias;
    logic gain2x;
    logic aux_is_fet;
    logic fet_block;
    logic sda_out;
    logic sda_oe;
    logic [6:0] addr;
    logic pack_fail_d;
  } state_s;

endpackage

// [design/alert_pulser.sv]
// Periodic short low pulse generator for the host alert
`timescale 1ns/1ps
`include "host_supervision_pins_defines.svh"

module alert_pulser #(
  parameter logic [31:0] PERIOD_CYC = `ALERT_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_run,
  // Output
  output logic o_alert_n
);

  localparam logic [31:0] PULSE_CYC = 32'(`ALERT_PULSE_CYC);

  host_supervision_pins_pkg::pulse_s st_reg;
  host_supervision_pins_pkg::pulse_s st_next;

  always_comb
  begin
    st_next = st_reg;
    if (!i_run)
    begin
      // Parked at the wrap so the first pulse is full width
      st_next.count = PERIOD_CYC - 32'h1;
      st_next.alert_n = 1'b1;
    end
    else
    begin
      // Pulse starts the moment the timeout is declared
      if (st_reg.count >= PERIOD_CYC - 32'h1)
        st_next.count = 32'h0;
      else
        st_next.count = st_reg.count + 32'h1;
      st_next.alert_n = (st_next.count >= PULSE_CYC);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      st_reg.count <= PERIOD_CYC - 32'h1;
      st_reg.alert_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign o_alert_n = st_reg.alert_n;

endmodule

// [design/host_supervision_pins.sv]
// Host supervision pins: watchdog, alert, pack fail and thermistor control
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "host_supervision_pins_defines.svh"

module host_supervision_pins #(
  parameter logic [31:0] WDT_STEP_CYC = 32'(`WDT_STEP_CYC),
  parameter logic [31:0] ALERT_PERIOD_CYC = 32'(`ALERT_PERIOD_CYC)
)
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Serial bus front end
  input wire logic I_ADDR_STRAP,
  input wire logic I_SERIAL_DATA_IN_PIN,
  input wire logic I_BUS_TXN_DONE,
  input wire logic I_BUS_DATA_OUT,
  input wire logic I_BUS_DATA_OE,
  output logic O_SERIAL_DATA_OUT_PIN,
  output logic O_SERIAL_DATA_OUT_OE,
  output logic O_SERIAL_DATA_SAMPLE,
  output logic [6:0] O_BUS_ADDR,
  // Measurement and faults
  input wire logic I_TEMP_MEAS_ACTIVE,
  input wire logic I_CELL_LOCKOUT,
  input wire logic I_CELL_FAIL,
  input wire logic I_OPEN_WIRE_FAIL,
  output logic O_THERMISTOR_BIAS_OUT,
  output logic O_TEMP_GAIN_2X,
  output logic O_AUX_IS_FET_TEMP,
  // Pins and system controls
  output logic O_HOST_ALERT_N,
  output logic O_PACK_FAIL_OUT,
  output logic O_FET_BLOCK,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  host_supervision_pins_pkg::state_s st_reg;
  host_supervision_pins_pkg::state_s st_next;

  logic pulse_alert_n;
  logic timed_out;
  logic any_ovr;
  logic fault_now;
  logic [31:0] wd_limit;
  logic [2:0] events;
  logic pulse_run;

  assign timed_out = (st_reg.wd == host_supervision_pins_pkg::WD_TIMED_OUT);
  // Start the pulser on the timeout edge so no high glitch precedes it
  assign pulse_run = (st_next.wd == host_supervision_pins_pkg::WD_TIMED_OUT);

  // ----------------------------------------------------------------
  // Alert pulse train
  // ----------------------------------------------------------------
  alert_pulser #(
    .PERIOD_CYC(ALERT_PERIOD_CYC)
  ) u_pulser (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .i_run(pulse_run),
    .o_alert_n(pulse_alert_n)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    any_ovr = st_reg.ovr[`OVR_FET] | st_reg.ovr[`OVR_BAL] |
              st_reg.ovr[`OVR_LMON] | st_reg.ovr[`OVR_CMON] |
              st_reg.ovr[`OVR_SCAN];
    // Setting zero disables the watchdog
    wd_limit = 32'(st_reg.wdt_set) * WDT_STEP_CYC;
    fault_now = I_CELL_LOCKOUT;
    if (st_reg.ctrl[`CTRL_CELL_FAIL_EN] && I_CELL_FAIL)
      fault_now = 1'b1;
    if (st_reg.ctrl[`CTRL_OPEN_WIRE_EN] && I_OPEN_WIRE_FAIL)
      fault_now = 1'b1;
    events = 3'h0;

    // Register writes
    if (I_WR)
    begin
      if (I_ADDR == `REG_CTRL)
        st_next.ctrl = I_WDATA;
      else if (I_ADDR == `REG_OVERRIDE)
        st_next.ovr = I_WDATA;
      else if (I_ADDR == `REG_WDT)
        st_next.wdt_set = I_WDATA[7:3];
      else if (I_ADDR == `REG_IRQ_MASK)
        st_next.irq_mask = I_WDATA[2:0];
      else if (I_ADDR == `REG_CHSEL)
        st_next.chsel = I_WDATA[3:0];
    end

    // Watchdog
    case (st_reg.wd)
      host_supervision_pins_pkg::WD_IDLE:
      begin
        st_next.wd_count = 32'h0;
        if (st_reg.wdt_set != 5'h0)
          st_next.wd = host_supervision_pins_pkg::WD_RUN;
      end
      host_supervision_pins_pkg::WD_RUN:
      begin
        if (st_reg.wdt_set == 5'h0)
          st_next.wd = host_supervision_pins_pkg::WD_IDLE;
        else if (I_BUS_TXN_DONE)
          st_next.wd_count = 32'h0;
        else if (st_reg.wd_count >= wd_limit - 32'h1)
        begin
          st_next.wd = host_supervision_pins_pkg::WD_TIMED_OUT;
          events[`EVT_TIMEOUT] = 1'b1;
        end
        else
          st_next.wd_count = st_reg.wd_count + 32'h1;
      end
      host_supervision_pins_pkg::WD_TIMED_OUT:
      begin
        if (I_BUS_TXN_DONE)
        begin
          // Balance override survives; others go back to the device
          st_next.ovr[`OVR_FET] = 1'b0;
          st_next.ovr[`OVR_LMON] = 1'b0;
          st_next.ovr[`OVR_CMON] = 1'b0;
          st_next.ovr[`OVR_SCAN] = 1'b0;
          st_next.ovr[`OVR_NVM] = 1'b0;
          st_next.wd_count = 32'h0;
          st_next.wd = host_supervision_pins_pkg::WD_RUN;
          events[`EVT_RESUME] = 1'b1;
        end
      end
      default:
        st_next.wd = host_supervision_pins_pkg::WD_IDLE;
    endcase

    // Block every FET while timed out and until the resume edge
    st_next.fet_block = (st_next.wd ==
      host_supervision_pins_pkg::WD_TIMED_OUT);

    // Alert: pulses while timed out, otherwise steady level on any override other than NVM
    if (timed_out)
      st_next.alert_n = pulse_alert_n;
    else if (any_ovr)
      st_next.alert_n = 1'b0;
    else
      st_next.alert_n = 1'b1;

    // Pack fail follows the fault state each cycle
    st_next.pack_fail = fault_now;
    st_next.pack_fail_d = fault_now;
    if (fault_now && !st_reg.pack_fail_d)
      events[`EVT_PACK_FAIL] = 1'b1;

    // Thermistor control
    if (st_reg.ovr[`OVR_SCAN])
      st_next.bias = (st_reg.chsel == `CHSEL_PACK_THERM) ||
                     (st_reg.chsel == `CHSEL_AUX_THERM);
    else
      st_next.bias = I_TEMP_MEAS_ACTIVE;
    st_next.gain2x = !st_reg.ctrl[`CTRL_TEMP_GAIN];
    // Pack input always feeds temperature faults; aux only on request
    st_next.aux_is_fet = st_reg.ctrl[`CTRL_FET_TEMP_SEL];

    // Serial pins: output pin only, input pin sampled separately
    st_next.sda_out = I_BUS_DATA_OUT;
    st_next.sda_oe = I_BUS_DATA_OE;
    st_next.addr = {`BUS_ADDR_UPPER, I_ADDR_STRAP};

    // Read data and interrupt status (read clears, set wins)
    st_next.rdata = 8'h00;
    if (I_RD)
    begin
      if (I_ADDR == `REG_CTRL)
        st_next.rdata = st_reg.ctrl;
      else if (I_ADDR == `REG_OVERRIDE)
        st_next.rdata = st_reg.ovr;
      else if (I_ADDR == `REG_WDT)
        st_next.rdata = {st_reg.wdt_set, 3'h0};
      else if (I_ADDR == `REG_STATUS)
        st_next.rdata = {4'h0, st_reg.pack_fail, st_reg.bias,
                         !st_reg.alert_n, timed_out};
      else if (I_ADDR == `REG_IRQ_STATUS)
        st_next.rdata = {5'h00, st_reg.irq_stat};
      else if (I_ADDR == `REG_IRQ_MASK)
        st_next.rdata = {5'h00, st_reg.irq_mask};
      else if (I_ADDR == `REG_CHSEL)
        st_next.rdata = {4'h0, st_reg.chsel};
    end
    if (I_RD && I_ADDR == `REG_IRQ_STATUS)
      st_next.irq_stat = events;
    else
      st_next.irq_stat = st_reg.irq_stat | events;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RSTN)
    begin
      st_reg.wd <= host_supervision_pins_pkg::WD_IDLE;
      st_reg.wd_count <= 32'h0;
      st_reg.ctrl <= 8'h00;
      st_reg.ovr <= 8'h00;
      st_reg.wdt_set <= 5'h00;
      st_reg.chsel <= 4'h0;
      st_reg.irq_stat <= 3'h0;
      st_reg.irq_mask <= 3'h0;
      st_reg.rdata <= 8'h00;
      st_reg.alert_n <= 1'b1;
      st_reg.irq <= 1'b0;
      st_reg.pack_fail <= 1'b0;
      st_reg.bias <= 1'b0;
      st_reg.gain2x <= 1'b1;
      st_reg.aux_is_fet <= 1'b0;
      st_reg.fet_block <= 1'b0;
      st_reg.sda_out <= 1'b1;
      st_reg.sda_oe <= 1'b0;
      st_reg.addr <= 7'h28;
      st_reg.pack_fail_d <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_RDATA = st_reg.rdata;
  assign O_SERIAL_DATA_OUT_PIN = st_reg.sda_out;
  assign O_SERIAL_DATA_OUT_OE = st_reg.sda_oe;
  assign O_SERIAL_DATA_SAMPLE = I_SERIAL_DATA_IN_PIN;
  assign O_BUS_ADDR = st_reg.addr;
  assign O_THERMISTOR_BIAS_OUT = st_reg.bias;
  assign O_TEMP_GAIN_2X = st_reg.gain2x;
  assign O_AUX_IS_FET_TEMP = st_reg.aux_is_fet;
  assign O_HOST_ALERT_N = st_reg.alert_n;
  assign O_PACK_FAIL_OUT = st_reg.pack_fail;
  assign O_FET_BLOCK = st_reg.fet_block;
  assign O_IRQ = st_reg.irq;

endmodule

// [sim/host_supervision_pins_sva.sv]
// Checker for the host supervision pin logic
`timescale 1ns/1ps
module host_supervision_pins_sva (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Inputs
  input wire logic I_ADDR_STRAP,
  input wire logic I_SERIAL_DATA_IN_PIN,
  input wire logic I_BUS_TXN_DONE,
  input wire logic I_CELL_LOCKOUT,
  input wire logic I_CELL_FAIL,
  input wire logic I_OPEN_WIRE_FAIL,
  // Outputs
  input wire logic O_SERIAL_DATA_SAMPLE,
  input wire logic [6:0] O_BUS_ADDR,
  input wire logic O_HOST_ALERT_N,
  input wire logic O_PACK_FAIL_OUT,
  input wire logic O_FET_BLOCK
);
  logic [7:0] low_cnt;
  logic armed;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  // ----------------------------------------
  // Alert pulse width while timed out
  // ----------------------------------------
  // Armed only after a high phase, so a steady override low is not counted
  always_ff @(posedge I_CORE_CLK)
  begin
    armed <= I_RSTN && O_FET_BLOCK && (armed || O_HOST_ALERT_N);
    if (!I_RSTN || O_HOST_ALERT_N)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end
  addr_lsb_a: assert property ($past(I_RSTN) |->
    O_BUS_ADDR == {6'h14, $past(I_ADDR_STRAP)})
    else $error("bus address does not follow strap");
  sample_pin_a: assert property (
    O_SERIAL_DATA_SAMPLE == I_SERIAL_DATA_IN_PIN)
    else $error("data sample not taken from input pin");
  lockout_fail_a: assert property (
    $past(I_RSTN) && $past(I_CELL_LOCKOUT) |-> O_PACK_FAIL_OUT)
    else $error("pack fail missing on lockout");
  unlatched_fail_a: assert property ($past(I_RSTN) &&
    !$past(I_CELL_LOCKOUT | I_CELL_FAIL | I_OPEN_WIRE_FAIL) |->
    !O_PACK_FAIL_OUT)
    else $error("pack fail held without fault");
  timeout_alert_a: assert property (
    $rose(O_FET_BLOCK) |-> ##[0:4] !O_HOST_ALERT_N)
    else $error("alert missing after timeout");
  pulse_width_a: assert property (
    armed && $rose(O_HOST_ALERT_N) && O_FET_BLOCK |-> low_cnt == 8'h32)
    else $error("alert pulse width wrong");
  block_hold_a: assert property (
    O_FET_BLOCK && !I_BUS_TXN_DONE |=> O_FET_BLOCK)
    else $error("fet block dropped without traffic");
  resume_clear_a: assert property (
    O_FET_BLOCK && I_BUS_TXN_DONE |=> !O_FET_BLOCK)
    else $error("fet block kept after traffic");
endmodule

bind host_supervision_pins host_supervision_pins_sva u_sva (
  .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_ADDR_STRAP(I_ADDR_STRAP),
  .I_SERIAL_DATA_IN_PIN(I_SERIAL_DATA_IN_PIN),
  .I_BUS_TXN_DONE(I_BUS_TXN_DONE), .I_CELL_LOCKOUT(I_CELL_LOCKOUT),
  .I_CELL_FAIL(I_CELL_FAIL), .I_OPEN_WIRE_FAIL(I_OPEN_WIRE_FAIL),
  .O_SERIAL_DATA_SAMPLE(O_SERIAL_DATA_SAMPLE), .O_BUS_ADDR(O_BUS_ADDR),
  .O_HOST_ALERT_N(O_HOST_ALERT_N), .O_PACK_FAIL_OUT(O_PACK_FAIL_OUT),
  .O_FET_BLOCK(O_FET_BLOCK));

// [sim/host_model.sv]
// Host side of the serial bus: transaction pulses and the wired data line
`timescale 1ns/1ps
module host_model #(
  parameter int GAP = 10
)
(
  // Clock
  input wire logic i_clk,
  // Bench control
  input wire logic i_en,
  input wire logic i_bit,
  // Device data output pin
  input wire logic i_dout,
  input wire logic i_doe,
  // Towards the device
  output logic o_sda,
  output logic o_txn
);
  int cnt = 0;
  initial o_txn = 1'b0;
  // Pull-up holds the line high unless someone pulls it low
  assign o_sda = !(i_doe && !i_dout) && (!i_en || i_bit);
  always @(posedge i_clk)
  begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    o_txn <= i_en && cnt == GAP - 1;
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the host supervision pin logic
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end
module testbench;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, strap = 1'b0;
  logic dout = 1'b1, doe = 1'b0, meas = 1'b0, host_bit = 1'b1;
  logic host_en = 1'b0, rd_seen = 1'b0, p;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, e;
  logic [2:0] flt = 3'h0;
  logic [6:0] baddr;
  logic sdi, txn, sdo, sdoe, samp, bias, gain, auxf, alert_n, pfail;
  logic block, irq;
  logic [31:0] seed = 32'h00014DF4;
  logic [1:0] d_prev = 2'h0;
  logic rstn_d = 1'b0;
  logic [7:0] exp_q[$];
  int n_fail = 0, compares = 0, t, f1, f2;
  always #10 clk = ~clk;
  host_supervision_pins #(.WDT_STEP_CYC(32'h0000000A),
    .ALERT_PERIOD_CYC(32'h000000C8)) u_dut (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ADDR_STRAP(strap),
    .I_SERIAL_DATA_IN_PIN(sdi), .I_BUS_TXN_DONE(txn),
    .I_BUS_DATA_OUT(dout), .I_BUS_DATA_OE(doe),
    .O_SERIAL_DATA_OUT_PIN(sdo), .O_SERIAL_DATA_OUT_OE(sdoe),
    .O_SERIAL_DATA_SAMPLE(samp), .O_BUS_ADDR(baddr),
    .I_TEMP_MEAS_ACTIVE(meas), .I_CELL_LOCKOUT(flt[0]),
    .I_CELL_FAIL(flt[1]), .I_OPEN_WIRE_FAIL(flt[2]),
    .O_THERMISTOR_BIAS_OUT(bias), .O_TEMP_GAIN_2X(gain),
    .O_AUX_IS_FET_TEMP(auxf), .O_HOST_ALERT_N(alert_n),
    .O_PACK_FAIL_OUT(pfail), .O_FET_BLOCK(block), .O_IRQ(irq));
  host_model #(.GAP(10)) u_host (.i_clk(clk), .i_en(host_en),
    .i_bit(host_bit), .i_dout(sdo), .i_doe(sdoe), .o_sda(sdi), .o_txn(txn));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic wrap_up;
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(d);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // ----------------------------------------
  // Random pin traffic and read monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    seed = xs(seed);
    dout <= seed[0];
    doe <= seed[1];
    host_bit <= seed[2];
    strap <= seed[3];
    if (rd_seen)
    begin
      e = exp_q.pop_front();
      `CHK(rdata, e)
    end
    rd_seen <= rd;
    // Output pin copies the engine's data one cycle later
    if (rstn_d)
      `CHK({sdo, sdoe}, d_prev)
    d_prev <= {dout, doe};
    rstn_d <= rstn;
  end
  initial
  begin
    repeat (4000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    `CHK(gain, 1'b1)
    `CHK(auxf, 1'b0)
    wr_reg(4'h0, 8'h30);
    cyc(2);
    `CHK(gain, 1'b0)
    `CHK(auxf, 1'b1)
    rd_reg(4'hB, 8'h00);
    // NVM and spare bit 1 alone must leave the alert idle; bits 2 to 6 must pull it low
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(4'h1, 8'h01 << i);
      cyc(2);
      `CHK(alert_n, i < 2)
    end
    @(posedge clk);
    meas <= 1'b1;
    cyc(2);
    `CHK(bias, 1'b1)
    @(posedge clk);
    meas <= 1'b0;
    cyc(2);
    `CHK(bias, 1'b0)
    wr_reg(4'h1, 8'h04);
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(4'h6, 8'(c));
      cyc(2);
      `CHK(bias, c == 1 || c == 2)
    end
    wr_reg(4'h5, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
        wr_reg(4'h0, 8'h81);
      @(posedge clk);
      flt <= 3'h1 << (i % 3);
      cyc(2);
      `CHK(pfail, i != 1 && i != 2)
      @(posedge clk);
      flt <= 3'h0;
      cyc(2);
      `CHK(pfail, 1'b0)
    end
    `CHK(irq, 1'b0)
    rd_reg(4'h4, 8'h04);
    wr_reg(4'h1, 8'h25);
    wr_reg(4'h2, 8'h10);
    host_en <= 1'b1;
    cyc(60);
    `CHK(block, 1'b0)
    @(posedge clk);
    host_en <= 1'b0;
    t = 0;
    while (block !== 1'b1 && t < 40)
    begin
      cyc(1);
      t++;
    end
    `CHK(t > 8 && t < 25, 1'b1)
    f1 = 0;
    f2 = 0;
    p = alert_n;
    for (t = 1; t < 460; t++)
    begin
      cyc(1);
      if (p === 1'b1 && alert_n === 1'b0)
      begin
        if (f1 == 0)
          f1 = t;
        else if (f2 == 0)
          f2 = t;
      end
      p = alert_n;
    end
    `CHK(f2 - f1, 200)
    `CHK(block, 1'b1)
    `CHK(irq, 1'b1)
    @(posedge clk);
    host_en <= 1'b1;
    t = 0;
    while (block !== 1'b0 && t < 20)
    begin
      cyc(1);
      t++;
    end
    `CHK(block, 1'b0)
    rd_reg(4'h1, 8'h20);
    rd_reg(4'h4, 8'h03);
    cyc(2);
    `CHK(irq, 1'b0)
    cyc(3);
    wrap_up();
  end
endmodule
